//--- core/serial_access_pkg.sv
// Purpose: Shared constants and types for the serial register access host.
// Assumes: 100 MHz system clock, 32-bit classic Wishbone register port.
// Notes:   Register offsets are byte addresses of aligned 32-bit words.
package serial_access_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ        = 100_000_000;
  localparam int I2C_FAST_HZ   = 400_000;
  // Quarter bit period rounded up, so the bus never runs faster than fast mode.
  localparam int QUARTER_CYCLES = (CLK_HZ + 4 * I2C_FAST_HZ - 1) / (4 * I2C_FAST_HZ);
  localparam logic [15:0] DIVIDER_RESET = 16'(QUARTER_CYCLES);

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] TXDATA_OFS  = 8'h04;
  localparam logic [7:0] RXDATA_OFS  = 8'h08;
  localparam logic [7:0] STATUS_OFS  = 8'h0C;
  localparam logic [7:0] DIVIDER_OFS = 8'h10;

  localparam int          GO_BIT      = 31;
  localparam int          BUSY_BIT    = 0;
  localparam int          DONE_BIT    = 1;
  localparam int          NACK_BIT    = 2;
  localparam logic [31:0] CTRL_WMASK  = 32'h0001_7F3F;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] DATA_RESET  = 32'h0000_0000;

  typedef struct packed {
    logic [14:0] zero_hi;
    logic        addr_lsb_strap;
    logic        zero_mid;
    logic [6:0]  reg_index;
    logic [1:0]  zero_lo;
    logic [1:0]  len_m1;
    logic        three_wire_select;
    logic        use_spi;
    logic        auto_increment_flag;
    logic        read;
  } ctrl_s;

  // ---------------------------------------------------------------------------
  // Protocol constants
  // ---------------------------------------------------------------------------
  localparam logic [5:0] BUS_ADDRESS_HI = 6'h0C;
  localparam logic [3:0] ACK_SLOT       = 4'h8;
  localparam logic [3:0] LAST_SPI_BIT   = 4'h7;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_I2C_START,
    ST_I2C_BYTE,
    ST_I2C_STOP,
    ST_SPI_SELECT,
    ST_SPI_BIT,
    ST_SPI_RELEASE
  } state_e;

  typedef enum logic [2:0] {
    STEP_ADDR_W,
    STEP_SUB,
    STEP_DATA_W,
    STEP_RSTART,
    STEP_ADDR_R,
    STEP_DATA_R
  } step_e;

endpackage : serial_access_pkg

//--- core/input_sync.sv
// Purpose: Two flip-flop synchroniser for a group of pin inputs.
// Assumes: Inputs are asynchronous to clk_i.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/1ps
module input_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '1;
      sync_o   <= '1;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end

endmodule : input_sync

//--- core/serial_access_host.sv
// Purpose: Host controller that reads and writes a sensor register file over
//          two-wire or three/four-wire serial bus, ordered from Wishbone.
// Assumes: External pull-ups on the clock and data pads; one device on the bus.
// Notes:   Up to four data bytes per transfer; bytes travel low byte first.
//
// Design decisions made here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
// What this block does
// - Start is data falling while clock high; bus busy until stop.
// - Transmitter releases data after each byte; receiver pulls it low to acknowledge.
// - Pointer byte follows address: low seven bits index, top bit auto-increment.
// - Read: address write, pointer, repeated start, address read, then data.
// - Write: address write, pointer, data bytes, each acknowledged, then stop.
// - Reading master acknowledges wanted bytes and withholds acknowledge on the last.
// - Two-wire bytes are eight bits, most significant first, up to four data bytes per transfer.
// - A receiver may hold the clock low; transfer waits until it is released.
// - Unaccepted address leaves data high in acknowledge slot; master may abandon.
// - Every two-wire transfer ends with a stop: data rising while clock high.
// - SPI chip select low for whole transaction; clock parked high while deselected.
// - SPI data changes on falling clock edge and is sampled on rising edge.
// - SPI single access is 16 clocks; bit 0 starts at first falling edge.
// - SPI bits 2 to 7 carry six-bit index, bits 8 to 15 data, MSB first.
// - Multi-byte SPI appends eight-clock blocks until chip select rises.
module serial_access_host
  import serial_access_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        serial_port_clock_i,
  output logic             serial_port_clock_o,
  output logic             serial_port_clock_oe_o,
  input  wire logic        serial_in_i,
  output logic             serial_in_o,
  output logic             serial_in_oe_o,
  input  wire logic        serial_out_i,
  output logic             cs_n_o
);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0]  sel);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return res;
  endfunction : merge_lanes

  function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] k);
    return w[{k, 3'b000} +: 8];
  endfunction : byte_of

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [2:0] pins_sync;
  logic       clk_line_s;
  logic       data_line_s;
  logic       serial_out_s;

  input_sync #(.WIDTH(3)) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i ({serial_port_clock_i, serial_in_i, serial_out_i}),
    .sync_o  (pins_sync)
  );

  assign clk_line_s   = pins_sync[2];
  assign data_line_s  = pins_sync[1];
  assign serial_out_s = pins_sync[0];

  // ---------------------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------------------
  ctrl_s       ctrl_reg;
  logic [31:0] tx_reg;
  logic [31:0] rx_reg;
  logic [15:0] divider_reg;
  logic        done_reg;
  logic        nack_reg;
  logic        start_reg;
  logic        ack_reg;
  logic [31:0] dat_reg;
  state_e      state_reg;
  logic        busy;
  logic        req;
  logic        wr;
  logic        finish;
  logic        nack_event;

  assign busy     = (state_reg != ST_IDLE) || start_reg;
  assign req      = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr       = req && wb_we_i;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= DATA_RESET;
    end else begin
      ack_reg <= req;
      if (req && !wb_we_i) begin
        unique case (wb_adr_i)
          CTRL_OFS:    dat_reg <= ctrl_reg;
          TXDATA_OFS:  dat_reg <= tx_reg;
          RXDATA_OFS:  dat_reg <= rx_reg;
          STATUS_OFS:  dat_reg <= {29'h0, nack_reg, done_reg, busy};
          DIVIDER_OFS: dat_reg <= {16'h0, divider_reg};
          default:     dat_reg <= DATA_RESET;
        endcase
      end
    end
  end

  // Configuration is frozen while a transfer runs so its fields stay coherent.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg    <= ctrl_s'(CTRL_RESET);
      tx_reg      <= DATA_RESET;
      divider_reg <= DIVIDER_RESET;
      start_reg   <= 1'b0;
    end else begin
      start_reg <= 1'b0;
      if (wr && !busy) begin
        if (wb_adr_i == CTRL_OFS) begin
          ctrl_reg  <= ctrl_s'(merge_lanes(ctrl_reg, wb_dat_i, wb_sel_i) & CTRL_WMASK);
          start_reg <= wb_sel_i[3] && wb_dat_i[GO_BIT];
        end
        if (wb_adr_i == TXDATA_OFS) begin
          tx_reg <= merge_lanes(tx_reg, wb_dat_i, wb_sel_i);
        end
        if (wb_adr_i == DIVIDER_OFS) begin
          divider_reg <= 16'(merge_lanes({16'h0, divider_reg}, wb_dat_i, wb_sel_i));
        end
      end
    end
  end

  // A completion or refusal in the same cycle as its clear stays set.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_reg <= 1'b0;
      nack_reg <= 1'b0;
    end else begin
      if (finish) begin
        done_reg <= 1'b1;
      end else if (wr && wb_adr_i == STATUS_OFS && wb_sel_i[0] && wb_dat_i[DONE_BIT]) begin
        done_reg <= 1'b0;
      end
      if (nack_event) begin
        nack_reg <= 1'b1;
      end else if (wr && wb_adr_i == STATUS_OFS && wb_sel_i[0] && wb_dat_i[NACK_BIT]) begin
        nack_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Quarter-bit tick divider
  // ---------------------------------------------------------------------------
  logic [15:0] cnt_reg;
  logic [15:0] div_m1;
  logic        tick;

  assign div_m1 = (divider_reg == 16'h0) ? 16'h0 : divider_reg - 16'h1;
  assign tick   = (state_reg != ST_IDLE) && (cnt_reg == 16'h0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 16'h0;
    end else if (state_reg == ST_IDLE || cnt_reg == 16'h0) begin
      cnt_reg <= div_m1;
    end else begin
      cnt_reg <= cnt_reg - 16'h1;
    end
  end

  // ---------------------------------------------------------------------------
  // Transfer engine
  // ---------------------------------------------------------------------------
  step_e       step_reg;
  logic [1:0]  q_reg;
  logic [3:0]  bitn_reg;
  logic [1:0]  nbytes_reg;
  logic [7:0]  shift_reg;
  logic        ack_bit_reg;
  logic        rx_mode_reg;
  logic        in_data_reg;
  logic        last_byte;
  logic        three_wire_read;
  logic [7:0]  addr_w_byte;
  logic [7:0]  addr_r_byte;
  logic [7:0]  sub_byte;
  logic [7:0]  spi_cmd_byte;

  assign last_byte       = (nbytes_reg == ctrl_reg.len_m1);
  assign three_wire_read = ctrl_reg.three_wire_select && ctrl_reg.read;
  assign addr_w_byte     = {BUS_ADDRESS_HI, ctrl_reg.addr_lsb_strap, 1'b0};
  assign addr_r_byte     = {BUS_ADDRESS_HI, ctrl_reg.addr_lsb_strap, 1'b1};
  assign sub_byte        = {ctrl_reg.auto_increment_flag, ctrl_reg.reg_index};
  assign spi_cmd_byte    = {ctrl_reg.read, ctrl_reg.auto_increment_flag,
                            ctrl_reg.reg_index[5:0]};

  assign finish     = tick && q_reg == 2'h3 &&
                      (state_reg == ST_I2C_STOP || state_reg == ST_SPI_RELEASE);
  assign nack_event = tick && state_reg == ST_I2C_BYTE && q_reg == 2'h3 &&
                      bitn_reg == ACK_SLOT && !rx_mode_reg && ack_bit_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg              <= ST_IDLE;
      step_reg               <= STEP_ADDR_W;
      q_reg                  <= 2'h0;
      bitn_reg               <= 4'h0;
      nbytes_reg             <= 2'h0;
      shift_reg              <= 8'h00;
      ack_bit_reg            <= 1'b1;
      rx_mode_reg            <= 1'b0;
      in_data_reg            <= 1'b0;
      rx_reg                 <= DATA_RESET;
      cs_n_o                 <= 1'b1;
      serial_port_clock_o    <= 1'b0;
      serial_port_clock_oe_o <= 1'b0;
      serial_in_o            <= 1'b0;
      serial_in_oe_o         <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (start_reg) begin
            q_reg       <= 2'h0;
            nbytes_reg  <= 2'h0;
            step_reg    <= STEP_ADDR_W;
            rx_mode_reg <= 1'b0;
            state_reg   <= ctrl_reg.use_spi ? ST_SPI_SELECT : ST_I2C_START;
          end
        end
        ST_I2C_START: if (tick) begin
          unique case (q_reg)
            2'h0: begin
              serial_in_o    <= 1'b0;
              serial_in_oe_o <= 1'b0;
              q_reg          <= 2'h1;
            end
            2'h1: begin
              serial_port_clock_oe_o <= 1'b0;
              q_reg                  <= 2'h2;
            end
            2'h2: if (clk_line_s) begin
              serial_in_oe_o <= 1'b1;
              q_reg          <= 2'h3;
            end
            2'h3: begin
              serial_port_clock_oe_o <= 1'b1;
              q_reg                  <= 2'h0;
              bitn_reg               <= 4'h0;
              shift_reg <= (step_reg == STEP_RSTART) ? addr_r_byte : addr_w_byte;
              step_reg  <= (step_reg == STEP_RSTART) ? STEP_ADDR_R : STEP_ADDR_W;
              state_reg <= ST_I2C_BYTE;
            end
          endcase
        end
        ST_I2C_BYTE: if (tick) begin
          unique case (q_reg)
            2'h0: begin
              if (bitn_reg == ACK_SLOT) begin
                serial_in_oe_o <= rx_mode_reg && !last_byte;
              end else begin
                serial_in_oe_o <= !rx_mode_reg && !shift_reg[7];
              end
              q_reg <= 2'h1;
            end
            2'h1: begin
              serial_port_clock_oe_o <= 1'b0;
              q_reg                  <= 2'h2;
            end
            2'h2: if (clk_line_s) begin
              if (bitn_reg == ACK_SLOT) begin
                ack_bit_reg <= data_line_s;
              end else begin
                shift_reg <= {shift_reg[6:0], data_line_s};
              end
              q_reg <= 2'h3;
            end
            2'h3: begin
              serial_port_clock_oe_o <= 1'b1;
              q_reg                  <= 2'h0;
              if (bitn_reg != ACK_SLOT) begin
                bitn_reg <= bitn_reg + 4'h1;
              end else begin
                bitn_reg <= 4'h0;
                // A refused byte abandons the transfer with a stop.
                if (!rx_mode_reg && ack_bit_reg) begin
                  state_reg <= ST_I2C_STOP;
                end else begin
                  unique case (step_reg)
                    STEP_ADDR_W: begin
                      step_reg  <= STEP_SUB;
                      shift_reg <= sub_byte;
                    end
                    STEP_SUB: begin
                      if (ctrl_reg.read) begin
                        step_reg  <= STEP_RSTART;
                        state_reg <= ST_I2C_START;
                      end else begin
                        step_reg  <= STEP_DATA_W;
                        shift_reg <= byte_of(tx_reg, 2'h0);
                      end
                    end
                    STEP_DATA_W: begin
                      if (last_byte) begin
                        state_reg <= ST_I2C_STOP;
                      end else begin
                        nbytes_reg <= nbytes_reg + 2'h1;
                        shift_reg  <= byte_of(tx_reg, nbytes_reg + 2'h1);
                      end
                    end
                    STEP_ADDR_R: begin
                      step_reg    <= STEP_DATA_R;
                      rx_mode_reg <= 1'b1;
                    end
                    STEP_DATA_R: begin
                      rx_reg[{nbytes_reg, 3'b000} +: 8] <= shift_reg;
                      if (last_byte) begin
                        state_reg <= ST_I2C_STOP;
                      end else begin
                        nbytes_reg <= nbytes_reg + 2'h1;
                      end
                    end
                    default: state_reg <= ST_I2C_STOP;
                  endcase
                end
              end
            end
          endcase
        end
        ST_I2C_STOP: if (tick) begin
          unique case (q_reg)
            2'h0: begin
              serial_in_oe_o <= 1'b1;
              q_reg          <= 2'h1;
            end
            2'h1: begin
              serial_port_clock_oe_o <= 1'b0;
              q_reg                  <= 2'h2;
            end
            2'h2: if (clk_line_s) begin
              q_reg <= 2'h3;
            end
            2'h3: begin
              serial_in_oe_o <= 1'b0;
              q_reg          <= 2'h0;
              state_reg      <= ST_IDLE;
            end
          endcase
        end
        ST_SPI_SELECT: if (tick) begin
          cs_n_o                 <= 1'b0;
          serial_port_clock_o    <= 1'b1;
          serial_port_clock_oe_o <= 1'b1;
          serial_in_oe_o         <= 1'b1;
          shift_reg              <= spi_cmd_byte;
          bitn_reg               <= 4'h0;
          in_data_reg            <= 1'b0;
          q_reg                  <= 2'h0;
          state_reg              <= ST_SPI_BIT;
        end
        ST_SPI_BIT: if (tick) begin
          unique case (q_reg)
            2'h0: begin
              serial_port_clock_o <= 1'b0;
              serial_in_o         <= shift_reg[7] && !(in_data_reg && ctrl_reg.read);
              // The shared pin is released so the device can return data on it.
              serial_in_oe_o      <= !(in_data_reg && three_wire_read);
              q_reg               <= 2'h1;
            end
            2'h1: q_reg <= 2'h2;
            2'h2: begin
              serial_port_clock_o <= 1'b1;
              shift_reg <= {shift_reg[6:0],
                            ctrl_reg.three_wire_select ? data_line_s : serial_out_s};
              q_reg <= 2'h3;
            end
            2'h3: begin
              q_reg <= 2'h0;
              if (bitn_reg != LAST_SPI_BIT) begin
                bitn_reg <= bitn_reg + 4'h1;
              end else begin
                bitn_reg <= 4'h0;
                if (!in_data_reg) begin
                  in_data_reg <= 1'b1;
                  shift_reg   <= ctrl_reg.read ? 8'h00 : byte_of(tx_reg, 2'h0);
                end else begin
                  if (ctrl_reg.read) begin
                    rx_reg[{nbytes_reg, 3'b000} +: 8] <= shift_reg;
                  end
                  // Select is raised only on a byte boundary, never mid-byte.
                  if (last_byte) begin
                    state_reg <= ST_SPI_RELEASE;
                  end else begin
                    nbytes_reg <= nbytes_reg + 2'h1;
                    shift_reg  <= ctrl_reg.read ? 8'h00 : byte_of(tx_reg, nbytes_reg + 2'h1);
                  end
                end
              end
            end
          endcase
        end
        ST_SPI_RELEASE: if (tick) begin
          unique case (q_reg)
            2'h0: begin
              cs_n_o         <= 1'b1;
              serial_in_o    <= 1'b0;
              serial_in_oe_o <= 1'b0;
              q_reg          <= 2'h1;
            end
            2'h1: q_reg <= 2'h2;
            2'h2: q_reg <= 2'h3;
            2'h3: begin
              // The pull-up keeps the clock parked high once the driver lets go.
              serial_port_clock_o    <= 1'b0;
              serial_port_clock_oe_o <= 1'b0;
              q_reg                  <= 2'h0;
              state_reg              <= ST_IDLE;
            end
          endcase
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule : serial_access_host

//--- verification/serial_access_assertions.sv
// Purpose: Port-level checks of the serial access host.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Only outputs driven by the host are judged.
`timescale 1ns/1ps
module serial_access_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic cs_n_o,
  input wire logic serial_port_clock_o,
  input wire logic serial_port_clock_oe_o,
  input wire logic serial_in_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // Frame bookkeeping
  // ----------------------------------------------------------------
  // Falling clock edges are counted so frame length can be judged at the end.
  logic       spc_q;
  logic [5:0] falls;
  always_ff @(posedge clk_i) begin
    spc_q <= serial_port_clock_o;
    if (rst_i || cs_n_o) falls <= 6'h00;
    else if (spc_q && !serial_port_clock_o) falls <= falls + 6'h01;
  end
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_select_clk_high: assert property ($fell(cs_n_o) |-> serial_port_clock_oe_o &&
    serial_port_clock_o) else $error("clock low at select");
  a_release_clk_high: assert property ($rose(cs_n_o) |-> serial_port_clock_oe_o &&
    serial_port_clock_o) else $error("clock low at release");
  a_frame_clk_driven: assert property (!cs_n_o |-> serial_port_clock_oe_o)
    else $error("clock undriven in frame");
  a_data_on_fall: assert property (!cs_n_o && $past(!cs_n_o) && $changed(serial_in_o)
    |-> $fell(serial_port_clock_o)) else $error("data moved off falling edge");
  a_frame_length: assert property ($rose(cs_n_o) |-> falls >= 6'h10 &&
    falls[2:0] == 3'h0) else $error("bad frame length");
endmodule : serial_access_checker

//--- verification/sensor_model.sv
// Purpose: Behavioural sensor seen from its pads.
// Assumes: Register file starts cleared.
// Notes:   Two-wire side only acknowledges writes to its own strapped address.
`timescale 1ns/1ps
module sensor_model (
  input  wire logic cs_n_i,
  input  wire logic spc_i,
  input  wire logic sdi_i,
  input  wire logic three_i,
  output logic      sdo_o,
  output logic      sdi_oe_o
);
  logic [7:0] mem [64];
  logic [7:0] cmd;
  logic [7:0] sh;
  logic [5:0] a;
  int         n;
  localparam logic STRAP = 1'b1;
  logic [7:0] ish;
  logic       ist, iok, iai;
  int         ib, nb;
  initial begin
    ist = 1'b0;
    foreach (mem[i]) mem[i] = 8'h00;
    sdo_o = 1'b0;
    sdi_oe_o = 1'b0;
  end
  always @(negedge cs_n_i) n = 0;
  // A released line must not keep showing the last bit.
  always @(posedge cs_n_i) begin
    sdi_oe_o = 1'b0;
    sdo_o = ~sdo_o;
  end
  always @(posedge spc_i) if (!cs_n_i) begin
    if (n < 8) cmd = {cmd[6:0], sdi_i};
    else sh = {sh[6:0], sdi_i};
    n = n + 1;
    if (n == 8) a = cmd[5:0];
    else if (n % 8 == 0) begin
      if (!cmd[7]) mem[a] = sh;
      if (cmd[6]) a = a + 6'h01;
    end
  end
  always @(negedge sdi_i) if (cs_n_i && spc_i) begin
    ist = 1'b1;
    ib = 0;
    nb = 0;
  end
  always @(posedge sdi_i) if (cs_n_i && spc_i) ist = 1'b0;
  always @(posedge spc_i) if (cs_n_i && ist) begin
    if (ib < 8) ish = {ish[6:0], sdi_i};
    ib = ib + 1;
  end
  always @(negedge spc_i) if (cs_n_i && ist) begin
    if (ib == 8) begin
      if (nb == 0) iok = (ish == {6'h0C, STRAP, 1'b0});
      sdo_o = 1'b0;
      sdi_oe_o = iok;
    end else if (ib == 9) begin
      sdi_oe_o = 1'b0;
      ib = 0;
      if (nb == 1) begin
        a = ish[5:0];
        iai = ish[7];
      end else if (nb > 1) begin
        mem[a] = ish;
        if (iai) a = a + 6'h01;
      end
      nb = nb + 1;
    end
  end
  always @(negedge spc_i) if (!cs_n_i && n >= 8 && cmd[7]) begin
    sdo_o = mem[a][7 - n % 8];
    sdi_oe_o = three_i;
  end
endmodule : sensor_model

//--- verification/tb_top.sv
// Purpose: Self-checking bench for the serial access host.
// Assumes: Divider shortened to 2 for run time.
// Notes:   Expected register contents are mirrored in the bench.
`timescale 1ns/1ps
module tb_top;
  import serial_access_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [3:0]  sel = 4'hF;
  logic [31:0] rdat, q, d, e, m;
  logic        ack, serial_port_clock, spc_oe, serial_in, sdi_oe, cs_n, serial_out, dev_oe, ai, tw;
  logic        three = 1'b0;
  logic [5:0]  idx;
  logic [1:0]  len;
  logic [7:0]  mir [64];
  int          n_fail = 0;
  int          checked = 0;
  int          cycles = 0;
  int          seed = 32'h4203;
  wire scl = spc_oe ? serial_port_clock : 1'b1;
  wire sda = sdi_oe ? serial_in : (dev_oe ? serial_out : 1'b1);
  always #5 clk_i = ~clk_i;
  serial_access_host dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .serial_port_clock_i(scl), .serial_port_clock_o(serial_port_clock),
    .serial_port_clock_oe_o(spc_oe), .serial_in_i(sda), .serial_in_o(serial_in),
    .serial_in_oe_o(sdi_oe), .serial_out_i(serial_out), .cs_n_o(cs_n));
  sensor_model dev (.cs_n_i(cs_n), .spc_i(scl), .sdi_i(sda), .three_i(three),
    .sdo_o(serial_out), .sdi_oe_o(dev_oe));
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] x);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= x;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
  endtask : wb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Busy is polled; a hang is cut short by the cycle ceiling below.
  task automatic run(input logic [31:0] c);
    wb(1'b1, CTRL_OFS, c | 32'h8000_0000);
    do wb(1'b0, STATUS_OFS, 32'h0); while (q[BUSY_BIT] !== 1'b0);
  endtask : run
  function automatic logic [31:0] ctrl(logic rd, logic [5:0] x);
    return {16'h0, 2'b00, x, 2'b00, len, tw, 1'b1, ai, rd};
  endfunction : ctrl
  function automatic logic [5:0] at(int k);
    return ai ? idx + 6'(k) : idx;
  endfunction : at
  task automatic print_verdict;
    $display("checked %0d failed %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      n_fail++;
      print_verdict;
    end
  end
  initial begin
    foreach (mir[i]) mir[i] = 8'h00;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, CTRL_OFS, 32'h0);
    chk(q, CTRL_RESET);
    wb(1'b0, DIVIDER_OFS, 32'h0);
    chk(q, 32'(DIVIDER_RESET));
    wb(1'b0, 8'h14, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, DIVIDER_OFS, 32'h2);
    run(32'h0000_2000);
    chk(q & 32'h7, 32'h6);
    wb(1'b1, STATUS_OFS, 32'h6);
    wb(1'b0, STATUS_OFS, 32'h0);
    chk(q & 32'h7, 32'h0);
    $display("two-wire refusal test done");
    d = $random(seed);
    wb(1'b1, TXDATA_OFS, d);
    run(32'h0001_0512);
    chk(q & 32'h7, 32'h2);
    run(32'h0000_0517);
    wb(1'b0, RXDATA_OFS, 32'h0);
    chk(q & 32'hFFFF, d & 32'hFFFF);
    $display("two-wire write test done");
    for (int i = 0; i < 14; i++) begin
      d = $random(seed);
      idx = (i == 0) ? 6'h3E : 6'($random(seed));
      len = (i < 2) ? 2'h3 : 2'($random(seed));
      ai = (i == 1) ? 1'b0 : 1'($random(seed));
      tw = 1'b0;
      wb(1'b1, TXDATA_OFS, d);
      run(ctrl(1'b0, idx));
      for (int k = 0; k <= len; k++) mir[at(k)] = d[8*k+:8];
      tw = (i < 2) ? 1'(i) : 1'($random(seed));
      three = tw;
      run(ctrl(1'b1, idx));
      wb(1'b0, RXDATA_OFS, 32'h0);
      e = 32'h0;
      m = 32'h0;
      for (int k = 0; k <= len; k++) begin
        e[8*k+:8] = mir[at(k)];
        m[8*k+:8] = 8'hFF;
      end
      chk(q & m, e);
      $display("serial access test %0d done", i);
    end
    print_verdict;
  end
endmodule : tb_top
bind serial_access_host serial_access_checker chk_i (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .cs_n_o(cs_n_o),
  .serial_port_clock_o(serial_port_clock_o),
  .serial_port_clock_oe_o(serial_port_clock_oe_o), .serial_in_o(serial_in_o));
